// >>> hdl/ufde_pkg.sv
// constants, types and state encodings for the serial transmitter/receiver with driver enable
// How it works
// - tx_holding_empty reads 1 when the holding register is free, 0 while full.
// - a written byte moves into the shift register and is sent automatically.
// - characters start only while tx_enable is set.
// - with parity_on and no ninth-bit mode, parity is generated and checked, even or odd.
// - ninth_bit_mode_on selects nine-bit operation; the ninth bit replaces parity.
// - in nine-bit mode the ninth bit sent is ninth_bit_tx_value: 1 address, 0 data.
// - transmit interrupt stands whenever the holding register is empty and transmit enabled.
// - rx_byte_ready is 1 while the receive data register holds a valid byte.
// - characters are received only while rx_enable is set.
// - receive interrupt fires on data and errors, or on errors only, by setting.
// - status shows whether a receive interrupt came from error, break or data.
// - automatic nine-bit schemes compare address bytes with the stored node address.
// - address_match_scheme picks the matching scheme in nine-bit mode.
// - active-low clear-to-send gates character starts only when flow_control_on is set.
// - clear-to-send is sampled one clock before each start; deasserted holds the character.
// - a character already being shifted is always finished.
// - driver_enable asserts when a byte is written and covers the whole frame.
// - driver_enable leads the start bit by one to two bit periods.
// - driver_enable releases one clock after the last stop bit.
// - driver_enable stays active between back-to-back characters.
// - driver_polarity sets the active level of driver_enable.
// - frame is low start, eight data bits lsb first, optional extra bit, 1 or 2 stops.
// - the ninth bit follows the eighth data bit and precedes the stop bits.
package ufde_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [15:0] MIN_BIT_CYCLES = 16'h0002;
  localparam int RX_FIFO_DEPTH = 32;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic LINE_START = 1'h0;

  // address matching schemes in nine-bit mode
  localparam logic [1:0] SCHEME_ALL = 2'h0;
  localparam logic [1:0] SCHEME_ADDR_ONLY = 2'h1;
  localparam logic [1:0] SCHEME_MATCH = 2'h2;
  localparam logic [1:0] SCHEME_MATCH_DATA = 2'h3;

  typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_WAIT, TX_START, TX_DATA, TX_EXTRA, TX_STOP, TX_TAIL} ufde_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} ufde_rx_state_t;

  // one received character with its status, as kept in the fifo
  typedef struct packed {
    logic brk;
    logic frame_err;
    logic par_err;
    logic new_frame;
    logic addr;
    logic [7:0] data;
  } ufde_rx_word_t;
endpackage : ufde_pkg

// >>> hdl/ufde_top.sv
// serial transmitter/receiver with flow control, driver enable and receive fifo
`timescale 1ns/10ps

module ufde_fifo #(
  parameter int W = 13,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ufde_fifo_st_t;

  ufde_fifo_st_t st;
  ufde_fifo_st_t next_st;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign in_ready_out = (st.wr[AW-1:0] != st.rd[AW-1:0]) || (st.wr[AW] == st.rd[AW]);
  assign out_valid_out = st.wr != st.rd;
  assign out_data_out = mem[st.rd[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    if (!rstn_in) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  // storage carries no reset
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[st.wr[AW-1:0]] <= in_data_in;
    end
  end
endmodule : ufde_fifo

module ufde_top #(
  parameter int DIV_W = 16,
  parameter int FIFO_DEPTH = ufde_pkg::RX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // configuration
  input wire logic [DIV_W-1:0] baud_div_in,
  input wire logic tx_enable_in,
  input wire logic rx_enable_in,
  input wire logic parity_on_in,
  input wire logic parity_odd_in,
  input wire logic two_stop_in,
  input wire logic ninth_bit_mode_on_in,
  input wire logic ninth_bit_tx_value_in,
  input wire logic [1:0] address_match_scheme_in,
  input wire logic [7:0] address_compare_in,
  input wire logic flow_control_on_in,
  input wire logic driver_polarity_in,
  input wire logic rx_irq_errors_only_in,
  // software data access
  input wire logic tx_write_in,
  input wire logic [7:0] tx_data_in,
  input wire logic rx_read_in,
  // status and interrupts
  output logic tx_holding_empty_out,
  output logic tx_irq_out,
  output logic rx_byte_ready_out,
  output logic [7:0] rx_data_out,
  output logic rx_addr_out,
  output logic rx_new_frame_out,
  output logic rx_parity_err_out,
  output logic rx_frame_err_out,
  output logic rx_break_out,
  output logic rx_overrun_out,
  output logic rx_irq_out,
  // serial pins
  output logic txd_out,
  input wire logic rxd_in,
  input wire logic cts_n_in,
  output logic driver_enable_out
);
  generate
    if (DIV_W < 2) begin : g_bad_div
      $error("divisor width must be at least 2");
    end
  endgenerate

  typedef struct packed {
    ufde_pkg::ufde_tx_state_t tx_state;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic tx_extra;
    logic tx_stop2;
    logic [7:0] hold;
    logic hold_empty;
    logic de_on;
    logic de_pin;
    logic txd;
    logic cts_seen;
    logic tx_irq;
    ufde_pkg::ufde_rx_state_t rx_state;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_ninth;
    logic in_frame;
    logic first_data;
    ufde_pkg::ufde_rx_word_t rx_word;
    logic rx_valid;
    logic overrun;
    logic rx_irq;
  } ufde_st_t;

  ufde_st_t st;
  ufde_st_t next_st;
  logic [DIV_W-1:0] period;
  logic tx_end;
  logic rx_end;
  logic cts_ok;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  ufde_pkg::ufde_rx_word_t push_word;
  ufde_pkg::ufde_rx_word_t fifo_out;

  // divisors below the minimum would make a bit shorter than the sampling needs
  assign period = (baud_div_in < DIV_W'(ufde_pkg::MIN_BIT_CYCLES)) ? DIV_W'(ufde_pkg::MIN_BIT_CYCLES) : baud_div_in;
  assign tx_end = st.tx_cnt == period - 1'b1;
  assign rx_end = st.rx_cnt == period - 1'b1;
  assign cts_ok = !flow_control_on_in || !st.cts_seen;
  assign fifo_out_ready = !st.rx_valid || rx_read_in;

  ufde_fifo #(
    .W($bits(ufde_pkg::ufde_rx_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out)
  );

  // whole next state: transmitter, receiver, data register
  always_comb begin
    next_st = st;
    push = 1'b0;
    push_word = '0;
    next_st.cts_seen = cts_n_in;
    // a write into a full holding register is dropped
    if (tx_write_in && st.hold_empty) begin
      next_st.hold = tx_data_in;
      next_st.hold_empty = 1'b0;
    end
    next_st.tx_cnt = tx_end ? '0 : st.tx_cnt + 1'b1;
    unique case (st.tx_state)
      ufde_pkg::TX_IDLE: begin
        next_st.tx_cnt = '0;
        if (tx_enable_in && !st.hold_empty) begin
          next_st.tx_state = ufde_pkg::TX_LEAD;
          next_st.de_on = 1'b1;
        end
      end
      ufde_pkg::TX_LEAD: begin
        if (tx_end) begin
          next_st.tx_state = ufde_pkg::TX_WAIT;
        end
      end
      ufde_pkg::TX_WAIT: begin
        next_st.tx_cnt = '0;
        if (!tx_enable_in || st.hold_empty) begin
          next_st.tx_state = ufde_pkg::TX_TAIL;
        end else if (cts_ok) begin
          // load shifter, ninth bit or parity sits above the data
          next_st.tx_shift[7:0] = st.hold;
          next_st.tx_shift[8] = ninth_bit_mode_on_in ? ninth_bit_tx_value_in : (^st.hold) ^ parity_odd_in;
          next_st.tx_extra = ninth_bit_mode_on_in || parity_on_in;
          next_st.tx_stop2 = two_stop_in;
          next_st.hold_empty = 1'b1;
          next_st.tx_state = ufde_pkg::TX_START;
        end
      end
      ufde_pkg::TX_START: begin
        if (tx_end) begin
          next_st.tx_state = ufde_pkg::TX_DATA;
          next_st.tx_bit = '0;
        end
      end
      ufde_pkg::TX_DATA: begin
        if (tx_end) begin
          next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
          next_st.tx_bit = st.tx_bit + 1'b1;
          if (st.tx_bit == ufde_pkg::LAST_DATA_BIT) begin
            next_st.tx_bit = '0;
            next_st.tx_state = st.tx_extra ? ufde_pkg::TX_EXTRA : ufde_pkg::TX_STOP;
          end
        end
      end
      ufde_pkg::TX_EXTRA: begin
        if (tx_end) begin
          next_st.tx_state = ufde_pkg::TX_STOP;
        end
      end
      ufde_pkg::TX_STOP: begin
        // clear-to-send is only looked at in the wait state
        if (tx_end) begin
          if (st.tx_stop2 && st.tx_bit == '0) begin
            next_st.tx_bit = 4'h1;
          end else if (tx_enable_in && !st.hold_empty) begin
            next_st.tx_state = ufde_pkg::TX_WAIT;
          end else begin
            next_st.tx_state = ufde_pkg::TX_TAIL;
          end
        end
      end
      ufde_pkg::TX_TAIL: begin
        next_st.tx_state = ufde_pkg::TX_IDLE;
        next_st.de_on = 1'b0;
      end
    endcase
    if (next_st.tx_state == ufde_pkg::TX_START) begin
      next_st.txd = ufde_pkg::LINE_START;
    end else if (next_st.tx_state == ufde_pkg::TX_DATA || next_st.tx_state == ufde_pkg::TX_EXTRA) begin
      next_st.txd = next_st.tx_shift[0];
    end else begin
      next_st.txd = ufde_pkg::LINE_IDLE;
    end
    next_st.de_pin = next_st.de_on ? driver_polarity_in : !driver_polarity_in;
    next_st.tx_irq = tx_enable_in && next_st.hold_empty;

    // receiver: bits sampled mid-cell, counted from the start bit centre
    next_st.rx_cnt = st.rx_cnt + 1'b1;
    unique case (st.rx_state)
      ufde_pkg::RX_IDLE: begin
        next_st.rx_cnt = '0;
        if (!rxd_in) begin
          next_st.rx_state = ufde_pkg::RX_START;
        end
      end
      ufde_pkg::RX_START: begin
        // one short of half a bit, so every later sample lands near the cell centre
        if (st.rx_cnt == (period >> 1) - 1'b1) begin
          next_st.rx_cnt = '0;
          next_st.rx_bit = '0;
          // a glitch shorter than half a bit is not a start
          next_st.rx_state = rxd_in ? ufde_pkg::RX_IDLE : ufde_pkg::RX_DATA;
        end
      end
      ufde_pkg::RX_DATA: begin
        if (rx_end) begin
          next_st.rx_cnt = '0;
          next_st.rx_shift = {rxd_in, st.rx_shift[7:1]};
          next_st.rx_bit = st.rx_bit + 1'b1;
          if (st.rx_bit == ufde_pkg::LAST_DATA_BIT) begin
            next_st.rx_ninth = 1'b0;
            next_st.rx_state = (ninth_bit_mode_on_in || parity_on_in) ? ufde_pkg::RX_EXTRA : ufde_pkg::RX_STOP;
          end
        end
      end
      ufde_pkg::RX_EXTRA: begin
        if (rx_end) begin
          next_st.rx_cnt = '0;
          next_st.rx_ninth = rxd_in;
          next_st.rx_state = ufde_pkg::RX_STOP;
        end
      end
      ufde_pkg::RX_STOP: begin
        if (rx_end) begin
          next_st.rx_state = ufde_pkg::RX_IDLE;
          push_word.data = st.rx_shift;
          push_word.frame_err = !rxd_in;
          push_word.brk = !rxd_in && st.rx_shift == '0 && !st.rx_ninth;
          push_word.par_err = parity_on_in && !ninth_bit_mode_on_in && ((^st.rx_shift) ^ st.rx_ninth ^ parity_odd_in);
          push_word.addr = ninth_bit_mode_on_in && st.rx_ninth;
          push = 1'b1;
          if (ninth_bit_mode_on_in) begin
            if (push_word.addr) begin
              // match state is tracked in every scheme, used by the automatic ones
              next_st.in_frame = st.rx_shift == address_compare_in;
              next_st.first_data = next_st.in_frame;
              unique case (address_match_scheme_in)
                ufde_pkg::SCHEME_ALL: push = 1'b1;
                ufde_pkg::SCHEME_ADDR_ONLY: push = 1'b1;
                ufde_pkg::SCHEME_MATCH: push = next_st.in_frame;
                ufde_pkg::SCHEME_MATCH_DATA: push = 1'b0;
              endcase
            end else begin
              push = address_match_scheme_in == ufde_pkg::SCHEME_ALL || (address_match_scheme_in[1] && st.in_frame);
              push_word.new_frame = st.first_data && address_match_scheme_in[1];
              if (push && address_match_scheme_in[1]) begin
                next_st.first_data = 1'b0;
              end
            end
            // errored characters always reach software
            push = push || push_word.frame_err;
          end
        end
      end
    endcase
    if (!rx_enable_in) begin
      next_st.rx_state = ufde_pkg::RX_IDLE;
      push = 1'b0;
    end

    // receive data register fed from the fifo
    if (fifo_out_valid && fifo_out_ready) begin
      next_st.rx_word = fifo_out;
      next_st.rx_valid = 1'b1;
    end else if (rx_read_in) begin
      next_st.rx_valid = 1'b0;
    end
    if (rx_read_in) begin
      next_st.overrun = 1'b0;
    end
    // a character lost to a full fifo sets overrun; the set wins over a read
    if (push && !fifo_in_ready) begin
      next_st.overrun = 1'b1;
    end
    if (rx_irq_errors_only_in) begin
      next_st.rx_irq = next_st.overrun || (next_st.rx_valid && (next_st.rx_word.frame_err ||
                       next_st.rx_word.par_err || next_st.rx_word.brk));
    end else begin
      next_st.rx_irq = next_st.rx_valid || next_st.overrun;
    end

    // synchronous reset
    if (!rstn_in) begin
      next_st = '0;
      next_st.hold_empty = 1'b1;
      next_st.txd = ufde_pkg::LINE_IDLE;
      next_st.cts_seen = 1'b1;
      next_st.de_pin = !driver_polarity_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    st <= next_st;
  end

  // outputs straight from the state register
  assign tx_holding_empty_out = st.hold_empty;
  assign tx_irq_out = st.tx_irq;
  assign rx_byte_ready_out = st.rx_valid;
  assign rx_data_out = st.rx_word.data;
  assign rx_addr_out = st.rx_word.addr;
  assign rx_new_frame_out = st.rx_word.new_frame;
  assign rx_parity_err_out = st.rx_word.par_err;
  assign rx_frame_err_out = st.rx_word.frame_err;
  assign rx_break_out = st.rx_word.brk;
  assign rx_overrun_out = st.overrun;
  assign rx_irq_out = st.rx_irq;
  assign txd_out = st.txd;
  assign driver_enable_out = st.de_pin;

  // checks on the guarded behaviour
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_LOAD_EMPTIES: assert property ($rose(st.tx_state == ufde_pkg::TX_START) |-> tx_holding_empty_out)
    else $error("holding register not freed at character start");
  AST_TX_GATED: assert property ((st.tx_state == ufde_pkg::TX_WAIT && !tx_enable_in)
    |=> st.tx_state != ufde_pkg::TX_START)
    else $error("character started while transmit disabled");
  AST_CTS_HOLD: assert property ((st.tx_state == ufde_pkg::TX_WAIT && flow_control_on_in && st.cts_seen
    && tx_enable_in) |=> st.tx_state != ufde_pkg::TX_START)
    else $error("character started while clear-to-send deasserted");
  AST_DE_FRAME: assert property ((st.tx_state inside {ufde_pkg::TX_START, ufde_pkg::TX_DATA,
    ufde_pkg::TX_EXTRA, ufde_pkg::TX_STOP}) |-> driver_enable_out == driver_polarity_in)
    else $error("driver enable inactive inside a frame");
  AST_DE_LEAD: assert property ($rose(st.de_on) |-> st.tx_state == ufde_pkg::TX_LEAD && st.tx_cnt == '0)
    else $error("driver enable did not start with a full lead period");
  AST_DE_TAIL: assert property ((st.tx_state == ufde_pkg::TX_STOP && tx_end && st.hold_empty &&
    !(st.tx_stop2 && st.tx_bit == '0)) |=> st.de_on ##1 !st.de_on)
    else $error("driver enable not released one clock after stop");
  AST_START_LOW: assert property ($rose(st.tx_state == ufde_pkg::TX_START) |-> !txd_out [*2])
    else $error("start bit not low");
  AST_STOP_HIGH: assert property ((st.tx_state inside {ufde_pkg::TX_STOP, ufde_pkg::TX_IDLE}) |-> txd_out)
    else $error("line not high in stop or idle");
  AST_TX_IRQ: assert property (tx_irq_out |-> tx_holding_empty_out)
    else $error("transmit interrupt without empty holding register");
  AST_READ_CLEARS: assert property ((rx_read_in && rx_byte_ready_out && !fifo_out_valid) |=> !rx_byte_ready_out)
    else $error("read did not clear byte-ready");

  COV_BACK_TO_BACK: cover property (st.tx_state == ufde_pkg::TX_STOP ##1 st.tx_state == ufde_pkg::TX_WAIT);
  COV_CTS_STALL: cover property (st.tx_state == ufde_pkg::TX_WAIT && flow_control_on_in && st.cts_seen [*3]);
  COV_RX_DELIVER: cover property ($rose(rx_byte_ready_out));
  COV_DE_RELEASE: cover property (st.tx_state == ufde_pkg::TX_TAIL);
endmodule : ufde_top

// >>> tb/ufde_remote.sv
// remote serial node: decodes what the block sends, drives clear-to-send and sends characters back
`timescale 1ns/10ps

module ufde_remote #(
  parameter int P = 4
) (
  // clock
  input wire logic clk_in,
  // line from the block, frame format and hold-off request
  input wire logic txd_in,
  input wire logic extra_in,
  input wire logic hold_in,
  // lines towards the block
  output logic rxd_out,
  output logic cts_n_out,
  // last character decoded
  output logic [8:0] got_out,
  output logic stop_out,
  output int frames_out
);
  // hold-off is registered, so cts moves a full clock ahead of any start
  always @(posedge clk_in) begin
    cts_n_out <= hold_in;
  end

  // sample every cell in its middle, well away from the block's launch edges
  initial begin
    frames_out = 0;
    rxd_out = 1'h1;
    got_out = 9'h000;
    stop_out = 1'h1;
    forever begin
      @(negedge txd_in);
      got_out = 9'h000;
      repeat (P / 2) @(posedge clk_in);
      for (int i = 0; i < 9; i++) begin
        if (i < 8 || extra_in) begin
          repeat (P) @(posedge clk_in);
          got_out[i] = txd_in;
        end
      end
      repeat (P) @(posedge clk_in);
      stop_out = txd_in;
      frames_out++;
    end
  end

  // one character lsb first, then the line idles high for a cell
  task automatic send(input logic [8:0] w, input int n, input logic stop);
    rxd_out = 1'h0;
    repeat (P) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      rxd_out = w[i];
      repeat (P) @(negedge clk_in);
    end
    rxd_out = stop;
    repeat (P) @(negedge clk_in);
    rxd_out = 1'h1;
    repeat (P) @(negedge clk_in);
  endtask : send
endmodule : ufde_remote

// >>> tb/testbench.sv
// self-checking bench for the serial block with driver enable and receive fifo
`timescale 1ns/10ps

module testbench;
  localparam int P = 4;
  // row flags: parity_on, parity_odd, ninth mode, ninth value, polarity, two stops
  typedef struct packed {logic [5:0] f; logic [7:0] d;} ufde_tb_row_t;
  localparam ufde_tb_row_t ROWS [5] = '{{6'h02, 8'ha5}, {6'h20, 8'h3c}, {6'h33, 8'h01},
    {6'h0c, 8'h7e}, {6'h2a, 8'hc3}};
  logic clk = 1'h0, rstn = 1'h0, tx_enable = 1'h0, ren = 1'h1, pon = 1'h0, podd = 1'h0, two = 1'h0;
  logic nbm = 1'h0, nbv = 1'h0, fce = 1'h0, pol = 1'h1, eo = 1'h0, wr = 1'h0, rd = 1'h0, hold = 1'h0;
  logic [1:0] sch = 2'h0;
  logic [7:0] acmp = 8'h42, wd = 8'h00, rdat;
  logic empty, tirq, rdy, raddr, rnew, rpe, rfe, rbrk, rovr, rirq, txd, de, rxd, cts_n, stp;
  logic [8:0] got;
  int fr, n_mismatch = 0, samples_checked = 0;

  // free-running clock, 20 ns period
  always #10 clk = ~clk;

  ufde_top ufde_top_inst (.ref_clk_in(clk), .rstn_in(rstn), .baud_div_in(16'h0004), .tx_enable_in(tx_enable),
    .rx_enable_in(ren), .parity_on_in(pon), .parity_odd_in(podd), .two_stop_in(two), .ninth_bit_mode_on_in(nbm),
    .ninth_bit_tx_value_in(nbv), .address_match_scheme_in(sch), .address_compare_in(acmp),
    .flow_control_on_in(fce), .driver_polarity_in(pol), .rx_irq_errors_only_in(eo), .tx_write_in(wr),
    .tx_data_in(wd), .rx_read_in(rd), .tx_holding_empty_out(empty), .tx_irq_out(tirq), .rx_byte_ready_out(rdy),
    .rx_data_out(rdat), .rx_addr_out(raddr), .rx_new_frame_out(rnew), .rx_parity_err_out(rpe),
    .rx_frame_err_out(rfe), .rx_break_out(rbrk), .rx_overrun_out(rovr), .rx_irq_out(rirq), .txd_out(txd),
    .rxd_in(rxd), .cts_n_in(cts_n), .driver_enable_out(de));

  ufde_remote #(.P(P)) ufde_remote_inst (.clk_in(clk), .txd_in(txd), .extra_in(pon | nbm), .hold_in(hold),
    .rxd_out(rxd), .cts_n_out(cts_n), .got_out(got), .stop_out(stp), .frames_out(fr));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic clk_n(input int n);
    repeat (n) @(negedge clk);
  endtask : clk_n

  task automatic put(input logic [7:0] d);
    wr = 1'h1;
    wd = d;
    clk_n(1);
    wr = 1'h0;
  endtask : put

  task automatic wait_frames(input int n);
    for (int i = 0; i < 3000 && fr < n; i++) clk_n(1);
  endtask : wait_frames

  // read until empty; seq compares each byte with its position
  task automatic drain(input logic seq, output int n, output logic [7:0] last, output logic nf);
    n = 0;
    while (rdy === 1'h1 && n < 40) begin
      if (seq) chk("fifo_data", rdat, n[8:0]);
      last = rdat;
      nf = rnew;
      rd = 1'h1;
      clk_n(1);
      rd = 1'h0;
      clk_n(2);
      n++;
    end
  endtask : drain

  // one character out and the same character back, with driver enable timing
  task automatic run_row(input ufde_tb_row_t r);
    logic has;
    logic [8:0] exp;
    int lead, len;
    {pon, podd, nbm, nbv, pol, two} = r.f;
    has = pon | nbm;
    exp = {nbm ? nbv : (pon & (^r.d ^ podd)), r.d};
    lead = 0;
    len = 0;
    clk_n(2);
    chk("de_idle", de, !pol);
    put(r.d);
    for (int i = 0; i < 200 && txd === 1'h1; i++) begin
      if (i == 1) chk("empty_full", empty, 1'h0);
      if (de === pol) lead++;
      clk_n(1);
    end
    chk("de_lead", (lead >= P && lead <= 2 * P), 1'h1);
    for (int i = 0; i < 400 && de === pol; i++) begin
      len++;
      clk_n(1);
    end
    chk("de_len", 9'(len), 9'((10 + has + two) * P + 1));
    chk("tx_char", got, exp);
    chk("tx_stop", stp, 1'h1);
    ufde_remote_inst.send(exp, 8 + has, 1'h1);
    clk_n(2);
    chk("rx_ready", rdy, 1'h1);
    chk("rx_data", {raddr, rdat}, {nbm & nbv, r.d});
    chk("rx_perr", rpe, 1'h0);
    rd = 1'h1;
    clk_n(1);
    rd = 1'h0;
    clk_n(2);
    chk("rx_clear", rdy, 1'h0);
  endtask : run_row

  // cut a hang short well past the expected run length
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin : main
    int n, gaps;
    logic [7:0] last;
    logic nf;
    clk_n(20);
    rstn = 1'h1;
    clk_n(1);
    chk("reset", {empty, de, txd, rdy, tirq}, 9'h014);
    tx_enable = 1'h1;
    clk_n(2);
    chk("tx_irq", tirq, 1'h1);
    foreach (ROWS[i]) run_row(ROWS[i]);
    {pon, nbm, two} = 3'h0;
    // enable dropped during the lead: the byte waits in the holding register and driver enable lets go
    n = fr;
    put(8'h55);
    clk_n(1);
    tx_enable = 1'h0;
    clk_n(20 * P);
    chk("tx_off", {fr == n, tirq, de === pol}, 9'h004);
    tx_enable = 1'h1;
    wait_frames(n + 1);
    chk("tx_on", got, 9'h055);
    // back to back: second write while the first is on the line
    put(8'h12);
    for (int i = 0; i < 200 && empty !== 1'h1; i++) clk_n(1);
    put(8'h34);
    gaps = 0;
    for (int i = 0; i < 300 && fr < n + 3; i++) begin
      if (de !== pol) gaps++;
      clk_n(1);
    end
    chk("de_gap", 9'(gaps), 9'h000);
    chk("b2b_char", got, 9'h034);
    clk_n(4);
    // flow control holds a start, is ignored when off, never cuts a character
    fce = 1'h1;
    hold = 1'h1;
    put(8'h66);
    clk_n(12 * P);
    chk("cts_hold", txd, 1'h1);
    fce = 1'h0;
    wait_frames(n + 4);
    chk("cts_off", got, 9'h066);
    fce = 1'h1;
    hold = 1'h0;
    put(8'h77);
    for (int i = 0; i < 200 && txd === 1'h1; i++) clk_n(1);
    hold = 1'h1;
    wait_frames(n + 5);
    chk("cts_mid", got, 9'h077);
    {hold, fce} = 2'h0;
    // address schemes: foreign frame then own frame
    nbm = 1'h1;
    for (int s = 0; s < 4; s++) begin
      sch = s[1:0];
      ufde_remote_inst.send(9'h111, 9, 1'h1);
      ufde_remote_inst.send(9'h0a1, 9, 1'h1);
      ufde_remote_inst.send(9'h142, 9, 1'h1);
      ufde_remote_inst.send(9'h0b2, 9, 1'h1);
      clk_n(2);
      drain(1'h0, n, last, nf);
      chk("scheme_count", 9'(n), (s == 0) ? 9'h004 : (s == 3) ? 9'h001 : 9'h002);
      chk("scheme_last", {nf, last}, (s == 1) ? 9'h042 : {s[1], 8'hb2});
    end
    {nbm, sch, pon, eo} = 5'h03;
    // interrupt on errors only: clean byte, bad parity, break
    ufde_remote_inst.send(9'h00f, 9, 1'h1);
    clk_n(2);
    chk("eo_clean", {rdy, rirq, rpe}, 9'h004);
    drain(1'h0, n, last, nf);
    ufde_remote_inst.send(9'h10f, 9, 1'h1);
    clk_n(2);
    chk("eo_perr", {rirq, rpe, rbrk}, 9'h006);
    drain(1'h0, n, last, nf);
    ufde_remote_inst.send(9'h000, 9, 1'h0);
    clk_n(2);
    chk("eo_break", {rirq, rfe, rbrk}, 9'h007);
    drain(1'h0, n, last, nf);
    {pon, eo, ren} = 3'h0;
    ufde_remote_inst.send(9'h0aa, 8, 1'h1);
    clk_n(2);
    chk("rx_off", rdy, 1'h0);
    ren = 1'h1;
    // fill register and fifo past capacity, then drain in order
    for (int i = 0; i < 34; i++) ufde_remote_inst.send(i[8:0], 8, 1'h1);
    clk_n(2);
    chk("overrun", {rovr, rirq}, 9'h003);
    drain(1'h1, n, last, nf);
    chk("fifo_count", 9'(n), 9'h021);
    chk("fifo_empty", rdy, 1'h0);
    stop_test();
  end
endmodule : testbench
